// *** hdl/novlc_pkg.sv ***
package novlc_pkg;

  // ----------------------------------------
  // Dictionary indices and subindices
  // ----------------------------------------
  localparam logic [15:0] IDX_RESTORE     = 16'h1011;
  localparam logic [15:0] IDX_DATA_BASE   = 16'h2000;
  localparam logic [15:0] IDX_LAYOUT      = 16'h2F00;
  localparam logic [15:0] IDX_ERASE_KEY   = 16'hF008;
  localparam logic [15:0] IDX_PROTECT     = 16'hF200;
  localparam logic [7:0]  SUB_COUNT       = 8'h00;
  localparam logic [7:0]  SUB_RESTORE     = 8'h01;
  localparam logic [7:0]  SUB_PROTECT     = 8'h02;
  localparam int          OBJ_STRIDE_LOG2 = 3;       // Eight indices per object

  // ----------------------------------------
  // Code words and field values
  // ----------------------------------------
  localparam logic [31:0] ERASE_KEY       = 32'hBECF6080;
  localparam logic [31:0] RESTORE_KEY     = 32'h64616F6C;
  localparam logic [31:0] RESTORE_KEY_ALT = 32'h6C6F6164;
  localparam logic [15:0] PROTECT_ON      = 16'h0001;
  localparam logic [15:0] PROTECT_OFF     = 16'h0000;

  // ----------------------------------------
  // Layout limits and defaults
  // ----------------------------------------
  localparam int          OBJ_MAX         = 127;
  localparam int          OBJ_BYTES_MAX   = 8190;
  localparam int          OBJ_SIZE_W      = 13;
  localparam logic [7:0]  DEFAULT_COUNT   = 8'h00;   // No objects defined on delivery
  localparam int          MEM_BYTES_DEF   = 131072;

  // ----------------------------------------
  // Sequencer states
  // ----------------------------------------
  typedef enum logic [1:0] {
    NOVLC_IDLE,
    NOVLC_WALK,
    NOVLC_ERASE
  } novlc_state_t;

endpackage

// *** hdl/novlc_store.sv ***
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------
// Byte store for object payload
// ----------------------------------------
module novlc_store #(
  parameter int AW = 17
) (
  // Clock
  input  wire logic          sys_clk,
  // Access port
  input  wire logic          we,
  input  wire logic [AW-1:0] addr,
  input  wire logic [7:0]    wdata,
  output logic      [7:0]    rdata_q
);

  logic [7:0] mem_q [0:(1<<AW)-1];

  // Single port, registered read
  always_ff @(posedge sys_clk)
  begin
    if (we)
    begin
      mem_q[addr] <= wdata;
    end
    rdata_q <= mem_q[addr];
  end

endmodule

`default_nettype wire

// *** hdl/novlc_layout_cfg.sv ***
// How it works
// RL1: Layout object holds count, then sizes
// RL2: Master sends 16-bit values, low byte first
// RL3: Layout applied at PREOP to SAFEOP, whole-object
// RL4: Object n sits at 0x2000 plus 8(n-1)
// RL5: Startup shows kept layout or default layout
// RL6: Erase key erases payload at INIT to PREOP
// RL7: Key-triggered erase also clears layout lock
// RL8: Lock set refuses any layout change; a restore value still resets the object count while locked
// RL9: Restore value returns backups to factory state
// RL10: Byte-reversed restore value also accepted
// RL11: Other restore values change nothing
// RL12: Layout change discards all stored payload
// RL13: Object sizes from 1 to 8190 bytes
// RL14: Locked layout write aborts, layout kept
`timescale 1ns/100ps
`default_nettype none

module novlc_layout_cfg
  import novlc_pkg::*;
#(
  parameter int MEM_BYTES = MEM_BYTES_DEF
) (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        nv_fresh,
  // Bus state transitions
  input  wire logic        trans_init_preop,
  input  wire logic        trans_preop_safeop,
  // Service data request
  input  wire logic        sdo_req,
  input  wire logic        sdo_wr,
  input  wire logic        sdo_whole,
  input  wire logic [15:0] sdo_index,
  input  wire logic [7:0]  sdo_sub,
  input  wire logic [12:0] sdo_offset,
  input  wire logic [31:0] sdo_wdata,
  // Service data answer
  output logic             sdo_ack_q,
  output logic             sdo_abort_q,
  output logic      [31:0] sdo_rdata_q,
  // Status
  output logic             busy_q,
  output logic             protect_q
);

  localparam int AW = $clog2(MEM_BYTES);

  // ----------------------------------------
  // State
  // ----------------------------------------
  novlc_state_t            state_q;
  logic [7:0]              count_q;
  logic [OBJ_SIZE_W-1:0]   size_q  [0:OBJ_MAX-1];
  logic [AW-1:0]           base_q  [0:OBJ_MAX-1];
  logic [7:0]              stage_cnt_q;
  logic [OBJ_SIZE_W-1:0]   stage_size_q [0:OBJ_MAX-1];
  logic                    stage_valid_q;
  logic                    erase_pend_q;
  logic [6:0]              walk_q;
  logic [AW:0]             acc_q;
  logic                    diff_q;
  logic [AW-1:0]           sweep_q;
  logic                    p1_valid_q;
  logic                    p1_abort_q;
  logic                    p1_data_q;
  logic [31:0]             p1_rdata_q;
  logic [7:0]              mem_rdata;

  // ----------------------------------------
  // Request decode
  // ----------------------------------------
  logic        hit_layout;
  logic        hit_protect;
  logic        hit_restore;
  logic        hit_key;
  logic        hit_data;
  logic [15:0] data_off;
  logic [6:0]  obj_i;
  logic [6:0]  sub_i;
  logic        sub_ok;
  logic        size_ok;
  logic        lay_wr;
  logic        lay_bad;
  logic        data_acc;
  logic        restore_hit;
  logic        key_hit;
  logic        idle;

  assign idle        = (state_q == NOVLC_IDLE);
  assign data_off    = sdo_index - IDX_DATA_BASE;
  assign obj_i       = data_off[OBJ_STRIDE_LOG2+6:OBJ_STRIDE_LOG2];
  assign sub_i       = 7'(sdo_sub - 8'h01);
  assign sub_ok      = (sdo_sub != SUB_COUNT) && (sdo_sub <= 8'(OBJ_MAX));
  assign hit_layout  = (sdo_index == IDX_LAYOUT);
  assign hit_protect = (sdo_index == IDX_PROTECT) && (sdo_sub == SUB_PROTECT);
  assign hit_restore = (sdo_index == IDX_RESTORE) && (sdo_sub == SUB_RESTORE);
  assign hit_key     = (sdo_index == IDX_ERASE_KEY) && (sdo_sub == SUB_COUNT);
  // Payload index must be on an eight-index boundary of a defined object
  assign hit_data    = (sdo_index >= IDX_DATA_BASE)                                     // RL4
                     && (data_off[OBJ_STRIDE_LOG2-1:0] == '0)
                     && (data_off[15:OBJ_STRIDE_LOG2+7] == '0)
                     && ({1'b0, obj_i} < count_q) && (sdo_sub == SUB_COUNT);
  assign data_acc    = hit_data && (sdo_offset < size_q[obj_i]);
  // Sizes out of range, counts beyond the table, and partial writes are refused
  assign size_ok     = (sdo_wdata[15:0] != 16'h0000) && (sdo_wdata[15:0] <= 16'(OBJ_BYTES_MAX)); // RL13
  assign lay_bad     = protect_q                                                         // RL8 RL14
                     || !sdo_whole                                                       // RL3
                     || ((sdo_sub == SUB_COUNT) ? (sdo_wdata[15:0] > 16'(OBJ_MAX))
                                                : (!sub_ok || !size_ok));
  assign lay_wr      = sdo_req && idle && sdo_wr && hit_layout && !lay_bad;
  assign restore_hit = sdo_req && idle && sdo_wr && hit_restore
                     && ((sdo_wdata == RESTORE_KEY) || (sdo_wdata == RESTORE_KEY_ALT)); // RL9 RL10 RL11
  assign key_hit     = sdo_req && idle && sdo_wr && hit_key && (sdo_wdata == ERASE_KEY);

  // ----------------------------------------
  // Payload store, shared with erase sweep
  // ----------------------------------------
  logic          st_we;
  logic [AW-1:0] st_addr;
  logic [7:0]    st_wdata;

  always_comb
  begin
    st_we    = 1'b0;
    st_addr  = AW'(base_q[obj_i] + AW'(sdo_offset));
    st_wdata = sdo_wdata[7:0];
    if (state_q == NOVLC_ERASE)
    begin
      st_we    = 1'b1;
      st_addr  = sweep_q;
      st_wdata = 8'h00;
    end
    else if (sdo_req && idle && sdo_wr && data_acc)
    begin
      st_we = 1'b1;
    end
  end

  novlc_store #(
    .AW (AW)
  ) u_store (
    .sys_clk (sys_clk),
    .we      (st_we),
    .addr    (st_addr),
    .wdata   (st_wdata),
    .rdata_q (mem_rdata)
  );

  // ----------------------------------------
  // Sequencer: layout walk and erase sweep
  // ----------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      state_q <= NOVLC_IDLE;
      walk_q  <= '0;
      acc_q   <= '0;
      diff_q  <= 1'b0;
      sweep_q <= '0;
    end
    else
    begin
      case (state_q)
        NOVLC_IDLE:
        begin
          walk_q  <= '0;
          acc_q   <= '0;
          sweep_q <= '0;
          diff_q  <= (stage_cnt_q != count_q);
          if (restore_hit)
            state_q <= NOVLC_ERASE;                           // RL9
          else if (trans_init_preop && erase_pend_q)
            state_q <= NOVLC_ERASE;                           // RL6
          else if (trans_preop_safeop && stage_valid_q && !protect_q)
            state_q <= NOVLC_WALK;                            // RL3
        end
        NOVLC_WALK:
        begin
          if ({1'b0, walk_q} >= stage_cnt_q)
          begin
            state_q <= diff_q ? NOVLC_ERASE : NOVLC_IDLE;     // RL12
          end
          else
          begin
            acc_q  <= acc_q + (AW+1)'(stage_size_q[walk_q]);
            diff_q <= diff_q || (stage_size_q[walk_q] != size_q[walk_q]);
            walk_q <= walk_q + 7'h01;
          end
        end
        NOVLC_ERASE:
        begin
          sweep_q <= sweep_q + 1'b1;
          if (sweep_q == AW'(MEM_BYTES - 1))
            state_q <= NOVLC_IDLE;
        end
        default:
          state_q <= NOVLC_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Active layout table, kept across reset
  // ----------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (state_q == NOVLC_WALK && {1'b0, walk_q} < stage_cnt_q)
    begin
      size_q[walk_q] <= stage_size_q[walk_q];                 // RL1
      base_q[walk_q] <= acc_q[AW-1:0];
    end
  end

  // Object count: kept value, or default on a fresh store
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      if (nv_fresh)
        count_q <= DEFAULT_COUNT;                             // RL5
    end
    else if (restore_hit)
      count_q <= DEFAULT_COUNT;                               // RL9
    else if (state_q == NOVLC_WALK && {1'b0, walk_q} >= stage_cnt_q)
      count_q <= stage_cnt_q;                                 // RL3
  end

  // Layout protection flag
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      if (nv_fresh)
        protect_q <= 1'b0;
    end
    else if (restore_hit)
      protect_q <= 1'b0;
    else if (trans_init_preop && erase_pend_q && idle)
      protect_q <= 1'b0;                                      // RL7
    else if (sdo_req && idle && sdo_wr && hit_protect)
      protect_q <= (sdo_wdata[15:0] == PROTECT_ON);           // RL8
  end

  // ----------------------------------------
  // Staged layout from the master
  // ----------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (lay_wr && sdo_sub != SUB_COUNT)
      stage_size_q[sub_i] <= sdo_wdata[OBJ_SIZE_W-1:0];       // RL2
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      stage_cnt_q   <= '0;
      stage_valid_q <= 1'b0;
    end
    else if (lay_wr)
    begin
      stage_valid_q <= 1'b1;
      if (sdo_sub == SUB_COUNT)
        stage_cnt_q <= sdo_wdata[7:0];                        // RL2
    end
    else if (state_q == NOVLC_WALK)
      stage_valid_q <= 1'b0;
  end

  // Erase request: a new key write wins over the clear
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      erase_pend_q <= 1'b0;
    else if (key_hit)
      erase_pend_q <= 1'b1;                                   // RL6
    else if (trans_init_preop && idle)
      erase_pend_q <= 1'b0;
  end

  // ----------------------------------------
  // Answer pipeline: two cycles for every request
  // ----------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      p1_valid_q <= 1'b0;
      p1_abort_q <= 1'b0;
      p1_data_q  <= 1'b0;
      p1_rdata_q <= '0;
    end
    else
    begin
      p1_valid_q <= sdo_req;
      p1_data_q  <= 1'b0;
      p1_rdata_q <= '0;
      p1_abort_q <= 1'b1;
      if (sdo_req && idle)
      begin
        if (hit_layout)
        begin
          p1_abort_q <= sdo_wr ? lay_bad : (sdo_sub != SUB_COUNT && !sub_ok); // RL14
          if (sdo_sub == SUB_COUNT)
            p1_rdata_q <= {24'h0, count_q};                   // RL1
          else if ({1'b0, sub_i} < count_q)
            p1_rdata_q <= {19'h0, size_q[sub_i]};
        end
        else if (hit_protect)
        begin
          p1_abort_q <= 1'b0;
          p1_rdata_q <= protect_q ? {16'h0, PROTECT_ON} : {16'h0, PROTECT_OFF};
        end
        else if (hit_restore || hit_key)
          p1_abort_q <= !sdo_wr;                              // RL11
        else if (data_acc)
        begin
          p1_abort_q <= 1'b0;
          p1_data_q  <= !sdo_wr;
        end
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      sdo_ack_q   <= 1'b0;
      sdo_abort_q <= 1'b0;
      sdo_rdata_q <= '0;
      busy_q      <= 1'b0;
    end
    else
    begin
      sdo_ack_q   <= p1_valid_q;
      sdo_abort_q <= p1_valid_q && p1_abort_q;
      sdo_rdata_q <= p1_data_q ? {24'h0, mem_rdata} : p1_rdata_q;
      busy_q      <= !idle;
    end
  end

endmodule

`default_nettype wire

// *** sim/novlc_layout_cfg_assertions.sv ***
`timescale 1ns/100ps
`default_nettype none
// ------------------------------
// Port checks
// ------------------------------
module novlc_layout_cfg_assertions
  import novlc_pkg::*;
(
  // Clock and reset
  input wire logic        sys_clk,
  input wire logic        rst_n,
  // Request
  input wire logic        sdo_req,
  input wire logic        sdo_wr,
  input wire logic        sdo_whole,
  input wire logic [15:0] sdo_index,
  input wire logic [7:0]  sdo_sub,
  input wire logic [31:0] sdo_wdata,
  // Answer
  input wire logic        sdo_ack_q,
  input wire logic        sdo_abort_q,
  input wire logic        protect_q
);
  logic lw;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // Layout write at the port
  assign lw = sdo_req && sdo_wr && sdo_index == IDX_LAYOUT;
  ack_latency_a: assert property (sdo_req |-> ##2 sdo_ack_q) else $error("late ack");
  ack_cause_a: assert property (sdo_ack_q |-> $past(sdo_req, 2)) else $error("stray ack");
  abort_ack_a: assert property (sdo_abort_q |-> sdo_ack_q) else $error("abort without ack");
  locked_refuse_a: assert property (lw && protect_q |-> ##2 sdo_abort_q) else $error("locked write taken");
  whole_needed_a: assert property (lw && !sdo_whole |-> ##2 sdo_abort_q) else $error("part write taken");
  size_range_a: assert property (lw && sdo_sub != SUB_COUNT && (sdo_wdata[15:0] == 16'h0000
    || sdo_wdata[15:0] > OBJ_BYTES_MAX) |-> ##2 sdo_abort_q) else $error("bad size taken");
  count_range_a: assert property (lw && sdo_sub == SUB_COUNT && sdo_wdata[15:0] > OBJ_MAX
    |-> ##2 sdo_abort_q) else $error("bad count taken");
  payload_sub_a: assert property (sdo_req && sdo_index[15:10] == 6'h08 && sdo_sub != 8'h00
    |-> ##2 sdo_abort_q) else $error("payload sub taken");
  key_read_a: assert property (sdo_req && !sdo_wr && (sdo_index == IDX_RESTORE
    || sdo_index == IDX_ERASE_KEY) |-> ##2 sdo_abort_q) else $error("key read taken");
  cover property (lw && protect_q);
  cover property (sdo_abort_q);
  cover property ($fell(protect_q));
endmodule
`default_nettype wire

// *** sim/novlc_master.sv ***
`timescale 1ns/100ps
`default_nettype none
// ------------------------------
// Field-bus master model
// ------------------------------
module novlc_master (
  // Clock
  input  wire logic        sys_clk,
  // Request
  output var logic         sdo_req,
  output var logic         sdo_wr,
  output var logic         sdo_whole,
  output var logic [15:0]  sdo_index,
  output var logic [7:0]   sdo_sub,
  output var logic [12:0]  sdo_offset,
  output var logic [31:0]  sdo_wdata,
  output var logic         trans_init_preop,
  output var logic         trans_preop_safeop,
  // Answer
  input  wire logic        sdo_ack_q,
  input  wire logic        sdo_abort_q,
  input  wire logic [31:0] sdo_rdata_q
);
  // Idle levels
  initial
  begin
    {sdo_req, sdo_wr, sdo_whole, sdo_index, sdo_sub, sdo_offset, sdo_wdata} = '0;
    {trans_init_preop, trans_preop_safeop} = 2'b00;
  end
  // One access; the answer is taken in the ack cycle
  task automatic sdo(input logic w, h, input logic [15:0] i, input logic [7:0] s,
                     input logic [12:0] o, input logic [31:0] d, output logic [31:0] r, output logic a);
    a = 1'bx;
    r = 'x;
    @(negedge sys_clk);
    {sdo_req, sdo_wr, sdo_whole, sdo_index, sdo_sub, sdo_offset, sdo_wdata} = {1'b1, w, h, i, s, o, d};
    @(negedge sys_clk);
    sdo_req = 1'b0;
    {sdo_index, sdo_sub, sdo_wdata} = ~{i, s, d}; // Released fields stop showing the last value
    repeat (4)
    begin
      @(negedge sys_clk);
      if (sdo_ack_q === 1'b1)
      begin
        r = sdo_rdata_q;
        a = sdo_abort_q;
      end
    end
  endtask
  // State transition pulse
  task automatic pulse(input logic ps);
    @(negedge sys_clk);
    trans_preop_safeop = ps;
    trans_init_preop = !ps;
    @(negedge sys_clk);
    {trans_init_preop, trans_preop_safeop} = 2'b00;
  endtask
endmodule
`default_nettype wire

// *** sim/novlc_layout_cfg_test.sv ***
`timescale 1ns/100ps
`default_nettype none
// ------------------------------
// Testbench
// ------------------------------
module novlc_layout_cfg_test
  import novlc_pkg::*;
;
  logic sys_clk = 1'b0, rst_n = 1'b0, nv_fresh = 1'b1, whole = 1'b1;
  wire logic req, wr, wh, tip, tps, ack, abt, busy, prot;
  wire logic [15:0] idx;
  wire logic [7:0] sub;
  wire logic [12:0] off;
  wire logic [31:0] wd, rd;
  int err_count = 0, samples_checked = 0, cyc = 0;
  logic [15:0] sz [4] = '{16'h0001, 16'h000A, 16'h0028, 16'h0003};
  logic [31:0] keys [2] = '{RESTORE_KEY, RESTORE_KEY_ALT};
  // Clock
  initial forever #2 sys_clk = ~sys_clk;
  novlc_master u_novlc_master (.sys_clk(sys_clk), .sdo_req(req), .sdo_wr(wr), .sdo_whole(wh), .sdo_index(idx),
    .sdo_sub(sub), .sdo_offset(off), .sdo_wdata(wd), .trans_init_preop(tip), .trans_preop_safeop(tps),
    .sdo_ack_q(ack), .sdo_abort_q(abt), .sdo_rdata_q(rd));
  novlc_layout_cfg #(.MEM_BYTES(64)) u_novlc_layout_cfg (.sys_clk(sys_clk), .rst_n(rst_n), .nv_fresh(nv_fresh),
    .trans_init_preop(tip), .trans_preop_safeop(tps), .sdo_req(req), .sdo_wr(wr), .sdo_whole(wh),
    .sdo_index(idx), .sdo_sub(sub), .sdo_offset(off), .sdo_wdata(wd), .sdo_ack_q(ack), .sdo_abort_q(abt),
    .sdo_rdata_q(rd), .busy_q(busy), .protect_q(prot));
  task automatic check(input string what, input logic [31:0] seen, exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Access with expected abort and, for reads, expected value
  task automatic xs(input logic w, input logic [15:0] i, input logic [7:0] s, input logic [12:0] o,
                    input logic [31:0] d, input logic ea, input logic [31:0] e);
    logic [31:0] r;
    logic a;
    u_novlc_master.sdo(w, whole, i, s, o, d, r, a);
    check("abort", {31'h0, a}, {31'h0, ea});
    if (!w && !ea)
      check("read", r, e);
  endtask
  task automatic idle();
    repeat (3) @(negedge sys_clk);
    for (int n = 0; n < 400 && busy !== 1'b0; n++)
      @(negedge sys_clk);
    check("busy", {31'h0, busy}, 32'h0);
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Hang guard
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_count++;
      close_out();
    end
  end
  // Test sequence
  initial
  begin
    repeat (10) @(negedge sys_clk);
    rst_n = 1'b1;
    xs(0, IDX_LAYOUT, SUB_COUNT, 0, 0, 0, 0);
    check("lock", {31'h0, prot}, 32'h0);
    $display("startup done");
    whole = 1'b0;
    xs(1, IDX_LAYOUT, SUB_COUNT, 0, 4, 1, 0);
    whole = 1'b1;
    xs(1, IDX_LAYOUT, 1, 0, 0, 1, 0);
    xs(1, IDX_LAYOUT, 1, 0, 8191, 1, 0);
    xs(1, IDX_LAYOUT, 4, 0, 8190, 0, 0);
    xs(1, IDX_LAYOUT, SUB_COUNT, 0, 128, 1, 0);
    xs(1, IDX_LAYOUT, SUB_COUNT, 0, 4, 0, 0);
    for (int k = 0; k < 4; k++)
      xs(1, IDX_LAYOUT, 8'(k + 1), 0, {16'h0, sz[k]}, 0, 0);
    u_novlc_master.pulse(1'b1);
    idle();
    xs(0, IDX_LAYOUT, SUB_COUNT, 0, 0, 0, 4);
    for (int k = 0; k < 4; k++)
      xs(0, IDX_LAYOUT, 8'(k + 1), 0, 0, 0, {16'h0, sz[k]});
    for (int k = 0; k < 4; k++)
      xs(1, IDX_DATA_BASE + 16'(8 * k), 0, 13'(sz[k] - 1), 32'hA0 + k, 0, 0);
    for (int k = 0; k < 4; k++)
      xs(0, IDX_DATA_BASE + 16'(8 * k), 0, 13'(sz[k] - 1), 0, 0, 32'hA0 + k);
    xs(0, IDX_DATA_BASE, 0, 1, 0, 1, 0);
    xs(0, IDX_DATA_BASE + 16'h4, 0, 0, 0, 1, 0);
    xs(0, IDX_DATA_BASE, 1, 0, 0, 1, 0);
    $display("layout done");
    xs(1, IDX_PROTECT, SUB_PROTECT, 0, 1, 0, 0);
    xs(0, IDX_PROTECT, SUB_PROTECT, 0, 0, 0, 1);
    xs(1, IDX_LAYOUT, SUB_COUNT, 0, 2, 1, 0);
    u_novlc_master.pulse(1'b1);
    idle();
    xs(0, IDX_LAYOUT, SUB_COUNT, 0, 0, 0, 4);
    xs(0, IDX_DATA_BASE + 16'h8, 0, 9, 0, 0, 32'hA1);
    $display("lock done");
    xs(1, IDX_ERASE_KEY, SUB_COUNT, 0, ERASE_KEY, 0, 0);
    u_novlc_master.pulse(1'b0);
    check("lock", {31'h0, prot}, 32'h0);
    idle();
    xs(0, IDX_DATA_BASE + 16'h8, 0, 9, 0, 0, 0);
    xs(0, IDX_LAYOUT, 2, 0, 0, 0, 10);
    $display("erase done");
    xs(1, IDX_DATA_BASE, 0, 0, 32'h5A, 0, 0);
    xs(1, IDX_LAYOUT, 1, 0, 2, 0, 0);
    u_novlc_master.pulse(1'b1);
    idle();
    xs(0, IDX_LAYOUT, 1, 0, 0, 0, 2);
    xs(0, IDX_DATA_BASE, 0, 0, 0, 0, 0);
    $display("change done");
    xs(1, IDX_DATA_BASE + 16'h8, 0, 3, 32'h3C, 0, 0);
    xs(1, IDX_PROTECT, SUB_PROTECT, 0, 1, 0, 0);
    // Mid-run reset with the store kept: layout, lock and payload survive
    nv_fresh = 1'b0;
    rst_n = 1'b0;
    repeat (2) @(negedge sys_clk);
    rst_n = 1'b1;
    xs(0, IDX_LAYOUT, SUB_COUNT, 0, 0, 0, 4);
    check("lock", {31'h0, prot}, 32'h1);
    xs(0, IDX_DATA_BASE + 16'h8, 0, 3, 0, 0, 32'h3C);
    $display("retention done");
    xs(1, IDX_RESTORE, SUB_RESTORE, 0, 32'h12345678, 0, 0);
    xs(0, IDX_LAYOUT, SUB_COUNT, 0, 0, 0, 4);
    xs(0, IDX_RESTORE, SUB_RESTORE, 0, 0, 1, 0);
    for (int j = 0; j < 2; j++)
    begin
      xs(1, IDX_PROTECT, SUB_PROTECT, 0, 0, 0, 0);
      xs(1, IDX_LAYOUT, SUB_COUNT, 0, 1, 0, 0);
      xs(1, IDX_LAYOUT, 1, 0, 1, 0, 0);
      u_novlc_master.pulse(1'b1);
      idle();
      xs(1, IDX_PROTECT, SUB_PROTECT, 0, 1, 0, 0);
      xs(1, IDX_RESTORE, SUB_RESTORE, 0, keys[j], 0, 0);
      idle();
      xs(0, IDX_LAYOUT, SUB_COUNT, 0, 0, 0, 0);
      check("lock", {31'h0, prot}, 32'h0);
    end
    $display("restore done");
    close_out();
  end
endmodule
bind novlc_layout_cfg novlc_layout_cfg_assertions u_novlc_layout_cfg_assertions (.sys_clk(sys_clk), .rst_n(rst_n),
  .sdo_req(sdo_req), .sdo_wr(sdo_wr), .sdo_whole(sdo_whole), .sdo_index(sdo_index), .sdo_sub(sdo_sub),
  .sdo_wdata(sdo_wdata), .sdo_ack_q(sdo_ack_q), .sdo_abort_q(sdo_abort_q), .protect_q(protect_q));
`default_nettype wire
